// ### rtl/sfrbk_pkg.sv
// package: special function register map and field layout
package sfrbk_pkg;
    // ----------------------------------------
    // register addresses in the sfr space
    // ----------------------------------------
    localparam logic [7:0] ADDR_ERASE_TRIG = 8'h94;
    localparam logic [7:0] ADDR_EE_DATA = 8'h9E;
    localparam logic [7:0] ADDR_EE_CTRL = 8'h9F;
    localparam logic [7:0] ADDR_FLASH_CTRL = 8'hB2;
    localparam logic [7:0] ADDR_BANK_SEL = 8'hB6;
    localparam logic [7:0] ADDR_PAGE_ADDR = 8'hB7;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hE8;
    localparam logic [7:0] ADDR_IRQ_WDOG = 8'hF8;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_PWE = 0;
    localparam int BIT_MEEN = 1;
    localparam int BIT_SECURE = 6;
    localparam int BIT_PREBOOT = 7;
    localparam int BIT_WDOG = 7;
    localparam int BIT_XFER = 0;
    localparam int BIT_RTC = 1;
    localparam int BIT_COL_BUSY = 2;
    localparam int BIT_COL_PASS = 3;
    localparam int BIT_PB = 4;
    localparam int BIT_WAKE = 5;
    localparam int BIT_PLL_RISE = 6;
    localparam int BIT_PLL_FALL = 7;
    localparam logic [6:0] PAGE_MAX = 7'h7F;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_BANK = 3'h0;
endpackage

// ### rtl/sfrbk_regs.sv
// module: device specific flash, flag and interrupt input registers
// Behaviour
// - erase trigger write starts mass or page erase
// - page address holds page 0-127, resets zero
// - write enable steers movx to flash
// - mass erase enable one shot, reset zero
// - secure bit set only, blocks readout
// - preboot status reads live sequence state
// - transfer busy flag set by event
// - one second flag set by tick
// - collision flag: write while engine busy
// - collision flag: write at pass start
// - pushbutton flag set on press
// - autowake flag set on timer wake
// - pll rise/fall flags, write zero clears
// - low seven bits show live irq inputs
// - writing one to top bit kicks watchdog
// - eeprom data and control registers read/write
module sfrbk_regs (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic sfr_wr, // sfr write strobe
    input wire logic sfr_rd, // sfr read strobe
    input wire logic [7:0] sfr_addr, // sfr address
    input wire logic [7:0] sfr_wdata, // sfr write data
    output logic [7:0] sfr_rdata, // registered read data
    input wire logic preboot_active, // preboot sequence running
    input wire logic transfer_busy_event, // transfer busy irq pulse
    input wire logic second_tick_event, // one second rtc pulse
    input wire logic write_while_engine_busy, // collision event
    input wire logic write_at_pass_start, // collision event
    input wire logic pushbutton_event, // pushbutton press pulse
    input wire logic autowake_event, // autowake timer wake
    input wire logic pll_rise_event, // pll rising pulse
    input wire logic pll_fall_event, // pll falling pulse
    input wire logic [6:0] ext_irq_pins, // external irq pins 0..6
    output logic mass_erase_start, // whole flash erase pulse
    output logic page_erase_start, // page erase pulse
    output logic [7:0] erase_trigger_value, // byte written to trigger
    output logic [6:0] page_erase_address_field, // page to erase
    output logic [2:0] flash_bank_select, // flash bank
    output logic program_write_enable, // movx writes to flash
    output logic mass_erase_enable, // mass erase permitted
    output logic secure, // block external readout
    output logic watchdog_restart, // watchdog kick pulse
    output logic [7:0] eeprom_data, // eeprom data register
    output logic [7:0] eeprom_control, // eeprom control register
    output logic eeprom_control_wr // control written pulse
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] ee_data_q, ee_data_d, ee_ctrl_q, ee_ctrl_d;
    logic ee_wr_q, ee_wr_d;
    logic [7:0] trig_val_q, trig_val_d;
    logic mass_go_q, mass_go_d, page_go_q, page_go_d;
    logic [6:0] page_q, page_d;
    logic [2:0] bank_q, bank_d;
    logic pwe_q, pwe_d, meen_q, meen_d, sec_q, sec_d;
    logic wd_q, wd_d;
    logic [7:0] flags_q, flags_d;
    logic [6:0] irq_s1_q, irq_s2_q;
    logic pre_s1_q, pre_s2_q;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] ev;

    // write decode helper
    function automatic logic hit(input logic [7:0] a);
        return sfr_wr && (sfr_addr == a);
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flop synchronisers for pins and preboot level
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_s1_q <= 7'h00;
            irq_s2_q <= 7'h00;
            pre_s1_q <= 1'b0;
            pre_s2_q <= 1'b0;
        end else begin
            irq_s1_q <= ext_irq_pins;
            irq_s2_q <= irq_s1_q;
            pre_s1_q <= preboot_active;
            pre_s2_q <= pre_s1_q;
        end
    end

    // ----------------------------------------
    // next state logic
    // ----------------------------------------
    // next state of control registers and flags
    always_comb begin
        ee_data_d = ee_data_q;
        ee_ctrl_d = ee_ctrl_q;
        if (hit(sfrbk_pkg::ADDR_EE_DATA)) begin
            ee_data_d = sfr_wdata;
        end
        if (hit(sfrbk_pkg::ADDR_EE_CTRL)) begin
            ee_ctrl_d = sfr_wdata;
        end
        ee_wr_d = hit(sfrbk_pkg::ADDR_EE_CTRL);
        trig_val_d = trig_val_q;
        mass_go_d = 1'b0;
        page_go_d = 1'b0;
        page_d = page_q;
        meen_d = meen_q;
        // trigger write picks mass or page erase
        if (hit(sfrbk_pkg::ADDR_ERASE_TRIG)) begin
            trig_val_d = sfr_wdata;
            // mass erase only when enabled, then consumed
            if (meen_q) begin
                mass_go_d = 1'b1;
                meen_d = 1'b0;
            end else begin
                page_go_d = 1'b1;
            end
        end
        if (hit(sfrbk_pkg::ADDR_PAGE_ADDR)) begin
            page_d = sfr_wdata[6:0];
        end
        bank_d = bank_q;
        if (hit(sfrbk_pkg::ADDR_BANK_SEL)) begin
            bank_d = sfr_wdata[2:0];
        end
        pwe_d = pwe_q;
        sec_d = sec_q;
        if (hit(sfrbk_pkg::ADDR_FLASH_CTRL)) begin
            pwe_d = sfr_wdata[sfrbk_pkg::BIT_PWE];
            meen_d = sfr_wdata[sfrbk_pkg::BIT_MEEN];
            sec_d = sec_q | sfr_wdata[sfrbk_pkg::BIT_SECURE];
        end
        // watchdog kick on a written one
        wd_d = hit(sfrbk_pkg::ADDR_IRQ_WDOG)
            && sfr_wdata[sfrbk_pkg::BIT_WDOG];
        ev = {pll_fall_event, pll_rise_event, autowake_event,
            pushbutton_event, write_at_pass_start,
            write_while_engine_busy, second_tick_event,
            transfer_busy_event};
        flags_d = flags_q;
        // written zeros clear, written ones ignored
        if (hit(sfrbk_pkg::ADDR_EVENT_FLAGS)) begin
            flags_d = flags_q & sfr_wdata;
        end
        flags_d = flags_d | ev;
        // read mux, registered
        rdata_d = rdata_q;
        if (sfr_rd) begin
            unique case (sfr_addr)
                sfrbk_pkg::ADDR_EE_DATA: rdata_d = ee_data_q;
                sfrbk_pkg::ADDR_EE_CTRL: rdata_d = ee_ctrl_q;
                sfrbk_pkg::ADDR_FLASH_CTRL: rdata_d = {pre_s2_q, sec_q,
                    4'h0, 1'b0, pwe_q};
                sfrbk_pkg::ADDR_BANK_SEL: rdata_d = {5'h00, bank_q};
                sfrbk_pkg::ADDR_PAGE_ADDR: rdata_d = {1'b0, page_q};
                sfrbk_pkg::ADDR_EVENT_FLAGS: rdata_d = flags_q;
                sfrbk_pkg::ADDR_IRQ_WDOG: rdata_d = {1'b0, irq_s2_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ee_data_q <= sfrbk_pkg::RST_BYTE;
            ee_ctrl_q <= sfrbk_pkg::RST_BYTE;
            ee_wr_q <= 1'b0;
            trig_val_q <= sfrbk_pkg::RST_BYTE;
            mass_go_q <= 1'b0;
            page_go_q <= 1'b0;
            page_q <= 7'h00;
            bank_q <= sfrbk_pkg::RST_BANK;
            pwe_q <= 1'b0;
            meen_q <= 1'b0;
            sec_q <= 1'b0;
            wd_q <= 1'b0;
            flags_q <= sfrbk_pkg::RST_BYTE;
            rdata_q <= sfrbk_pkg::RST_BYTE;
        end else begin
            ee_data_q <= ee_data_d;
            ee_ctrl_q <= ee_ctrl_d;
            ee_wr_q <= ee_wr_d;
            trig_val_q <= trig_val_d;
            mass_go_q <= mass_go_d;
            page_go_q <= page_go_d;
            page_q <= page_d;
            bank_q <= bank_d;
            pwe_q <= pwe_d;
            meen_q <= meen_d;
            sec_q <= sec_d;
            wd_q <= wd_d;
            flags_q <= flags_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // outputs straight from flops
    assign sfr_rdata = rdata_q;
    assign mass_erase_start = mass_go_q;
    assign page_erase_start = page_go_q;
    assign erase_trigger_value = trig_val_q;
    assign page_erase_address_field = page_q;
    assign flash_bank_select = bank_q;
    assign program_write_enable = pwe_q;
    assign mass_erase_enable = meen_q;
    assign secure = sec_q;
    assign watchdog_restart = wd_q;
    assign eeprom_data = ee_data_q;
    assign eeprom_control = ee_ctrl_q;
    assign eeprom_control_wr = ee_wr_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_secure_sticky: assert property (secure |=> secure)
        else $error("secure bit dropped");
    a_erase_select: assert property (
        sfr_wr && sfr_addr == 8'h94 |=>
        (mass_erase_start != page_erase_start))
        else $error("erase trigger gave wrong start");
    a_meen_consumed: assert property (
        mass_erase_start |-> !mass_erase_enable)
        else $error("mass erase enable not consumed");
    a_flag_set_wins: assert property (
        sfr_wr && sfr_addr == sfrbk_pkg::ADDR_EVENT_FLAGS
        |=> (flags_q & $past(ev)) == $past(ev))
        else $error("event lost under a clear");
    a_pll_clear: assert property (
        sfr_wr && sfr_addr == 8'hE8 && !sfr_wdata[6] && !pll_rise_event
        |=> !flags_q[6])
        else $error("pll rise flag not cleared");
    a_wdog_kick: assert property (
        watchdog_restart |-> $past(sfr_wr) && $past(sfr_wdata[7])
        && $past(sfr_addr) == 8'hF8)
        else $error("spurious watchdog kick");
    a_irq_live: assert property (
        sfr_rd && sfr_addr == 8'hF8 |=> sfr_rdata[6:0] == $past(irq_s2_q))
        else $error("irq inputs not live");
    a_page_hold: assert property (
        !(sfr_wr && sfr_addr == 8'hB7) |=> $stable(page_erase_address_field))
        else $error("page address changed");
    a_tick_flag: assert property (
        second_tick_event |=> flags_q[1])
        else $error("second tick flag not set");
    // transfer, collision, pushbutton and autowake events set their flags; a flag write sets none
    a_xfer_flag: assert property (
        transfer_busy_event |=> flags_q[sfrbk_pkg::BIT_XFER])
        else $error("transfer busy flag not set");
    a_busy_col_flag: assert property (
        write_while_engine_busy |=> flags_q[sfrbk_pkg::BIT_COL_BUSY])
        else $error("busy collision flag not set");
    a_pass_col_flag: assert property (
        write_at_pass_start |=> flags_q[sfrbk_pkg::BIT_COL_PASS])
        else $error("pass collision flag not set");
    a_pb_flag: assert property (
        pushbutton_event |=> flags_q[sfrbk_pkg::BIT_PB])
        else $error("pushbutton flag not set");
    a_wake_flag: assert property (
        autowake_event |=> flags_q[sfrbk_pkg::BIT_WAKE])
        else $error("autowake flag not set");
    a_flag_only_clear: assert property (
        sfr_wr && sfr_addr == sfrbk_pkg::ADDR_EVENT_FLAGS
        |=> (flags_q & ~$past(flags_q) & ~$past(ev)) == 8'h00)
        else $error("flag write set a flag");
    // register fields and strobes
    a_wdog_fires: assert property (
        sfr_wr && sfr_addr == sfrbk_pkg::ADDR_IRQ_WDOG
        && sfr_wdata[sfrbk_pkg::BIT_WDOG] |=> watchdog_restart)
        else $error("watchdog kick missing");
    a_mass_needs_enable: assert property (
        mass_erase_start |-> $past(mass_erase_enable))
        else $error("mass erase without enable");
    a_pwe_follows: assert property (
        sfr_wr && sfr_addr == sfrbk_pkg::ADDR_FLASH_CTRL
        |=> program_write_enable == $past(sfr_wdata[sfrbk_pkg::BIT_PWE]))
        else $error("program write enable not written");
    a_meen_write: assert property (
        sfr_wr && sfr_addr == sfrbk_pkg::ADDR_FLASH_CTRL
        |=> mass_erase_enable == $past(sfr_wdata[sfrbk_pkg::BIT_MEEN]))
        else $error("mass erase enable not written");
    a_ee_ctrl_pulse: assert property (
        eeprom_control_wr |-> eeprom_control == $past(sfr_wdata))
        else $error("eeprom control strobe without write");
    a_preboot_read: assert property (
        sfr_rd && sfr_addr == sfrbk_pkg::ADDR_FLASH_CTRL
        |=> sfr_rdata[sfrbk_pkg::BIT_PREBOOT] == $past(pre_s2_q))
        else $error("preboot status not live");

    c_mass: cover property (mass_erase_start);
    c_page: cover property (page_erase_start);
    c_kick: cover property (watchdog_restart);
    c_secure_set: cover property ($rose(secure));
    c_clear_collide: cover property (sfr_wr && sfr_addr == 8'hE8
        && pll_rise_event);
endmodule

// ### verification/sfrbk_regs_test.sv
// file: self-checking bench for the flash, flag and irq register bank
module sfrbk_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, sfr_wr, sfr_rd, preboot_active;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ev, rnd, trig_val, ee_d, ee_c;
    logic [6:0] pins, pg;
    logic [2:0] bank;
    logic mstart, pstart, pwe, meen, sec, wdog, ee_wr;
    int err_count, checks;
    // ----------------------------------------
    // design under test
    // ----------------------------------------
    sfrbk_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .preboot_active(preboot_active),
        .transfer_busy_event(ev[0]), .second_tick_event(ev[1]),
        .write_while_engine_busy(ev[2]), .write_at_pass_start(ev[3]),
        .pushbutton_event(ev[4]), .autowake_event(ev[5]),
        .pll_rise_event(ev[6]), .pll_fall_event(ev[7]),
        .ext_irq_pins(pins), .mass_erase_start(mstart),
        .page_erase_start(pstart), .erase_trigger_value(trig_val),
        .page_erase_address_field(pg), .flash_bank_select(bank),
        .program_write_enable(pwe), .mass_erase_enable(meen),
        .secure(sec), .watchdog_restart(wdog), .eeprom_data(ee_d),
        .eeprom_control(ee_c), .eeprom_control_wr(ee_wr));
    // free running 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // repeatable pseudo random step
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    // one write strobe, outputs settled on return
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        #1;
    endtask
    // one read strobe, masked compare of the returned byte
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                          input logic [7:0] m = 8'hFF);
        @(posedge clk_sys);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        check(sfr_rdata & m, exp);
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 8'h00;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #20000;
        err_count++;
        give_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, sfr_wr, sfr_rd, preboot_active} = 4'h0;
        {sfr_addr, sfr_wdata, ev, pins} = '0;
        rnd = 8'h62;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        check({1'b0, pwe, meen, sec, mstart, pstart, wdog, ee_wr},
            8'h00);
        rd_chk(sfrbk_pkg::ADDR_PAGE_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            @(posedge clk_sys);
            pins <= rnd[6:0];
            wr(sfrbk_pkg::ADDR_PAGE_ADDR, {1'b0, rnd[6:0]});
            check({1'b0, pg}, {1'b0, rnd[6:0]});
            rd_chk(sfrbk_pkg::ADDR_PAGE_ADDR, {1'b0, rnd[6:0]});
            wr(sfrbk_pkg::ADDR_BANK_SEL, rnd);
            check({5'h00, bank}, {5'h00, rnd[2:0]});
            wr(sfrbk_pkg::ADDR_EE_DATA, rnd);
            wr(sfrbk_pkg::ADDR_EE_CTRL, ~rnd);
            check_bit(ee_wr, 1'b1);
            check(ee_d, rnd);
            check(ee_c, ~rnd);
            rd_chk(sfrbk_pkg::ADDR_EE_DATA, rnd);
            rd_chk(sfrbk_pkg::ADDR_EE_CTRL, ~rnd);
            rd_chk(sfrbk_pkg::ADDR_IRQ_WDOG, {1'b0, rnd[6:0]}, 8'h7F);
        end
        wr(sfrbk_pkg::ADDR_PAGE_ADDR, 8'h7F);
        rd_chk(sfrbk_pkg::ADDR_PAGE_ADDR, 8'h7F);
        // mass erase armed, then a plain page erase
        wr(sfrbk_pkg::ADDR_FLASH_CTRL, 8'h02);
        check_bit(meen, 1'b1);
        rd_chk(sfrbk_pkg::ADDR_FLASH_CTRL, 8'h00, 8'h02);
        wr(sfrbk_pkg::ADDR_ERASE_TRIG, 8'hA5);
        check({5'h00, mstart, pstart, meen}, 8'h04);
        check(trig_val, 8'hA5);
        wr(sfrbk_pkg::ADDR_PAGE_ADDR, {1'b0, rnd[6:0]});
        wr(sfrbk_pkg::ADDR_ERASE_TRIG, 8'h5A);
        check({5'h00, mstart, pstart, meen}, 8'h02);
        check({1'b0, pg}, {1'b0, rnd[6:0]});
        rd_chk(sfrbk_pkg::ADDR_ERASE_TRIG, 8'h00);
        // write enable follows writes, secure only sets
        wr(sfrbk_pkg::ADDR_FLASH_CTRL, 8'h41);
        check({6'h00, pwe, sec}, 8'h03);
        wr(sfrbk_pkg::ADDR_FLASH_CTRL, 8'h00);
        check({6'h00, pwe, sec}, 8'h01);
        @(posedge clk_sys);
        preboot_active <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(sfrbk_pkg::ADDR_FLASH_CTRL, 8'hC0, 8'hC1);
        @(posedge clk_sys);
        preboot_active <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd_chk(sfrbk_pkg::ADDR_FLASH_CTRL, 8'h40, 8'hC1);
        // watchdog kick only on a one in the top bit
        wr(sfrbk_pkg::ADDR_IRQ_WDOG, 8'h80);
        check_bit(wdog, 1'b1);
        wr(sfrbk_pkg::ADDR_IRQ_WDOG, 8'h7F);
        check_bit(wdog, 1'b0);
        // every event flag: set, ones ignored, masked clear
        wr(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            wr(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'hFF);
            rd_chk(sfrbk_pkg::ADDR_EVENT_FLAGS,
                8'h01 << i);
            wr(sfrbk_pkg::ADDR_EVENT_FLAGS, ~(8'h01 << i));
            rd_chk(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'h00);
        end
        // event lands in the same cycle as a clear of all flags
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= sfrbk_pkg::ADDR_EVENT_FLAGS;
        sfr_wdata <= 8'h00;
        ev <= 8'h81;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        ev <= 8'h00;
        rd_chk(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'h81);
        wr(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'hFE);
        rd_chk(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'h80);
        // chip reset in mid run: control bits, strobes, page address and flags back to zero
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        check({1'b0, pwe, meen, sec, mstart, pstart, wdog, ee_wr},
            8'h00);
        check({1'b0, pg}, 8'h00);
        rd_chk(sfrbk_pkg::ADDR_EVENT_FLAGS, 8'h00);
        rd_chk(sfrbk_pkg::ADDR_FLASH_CTRL, 8'h00);
        give_verdict();
    end
endmodule
